// file: rtl/rxcd_regs.svh
// Purpose: Register map, reset values and fixed counts of the receive
//          cell and frame delineation block.
// Assumes: 10-bit register address, 8-bit register data.
// Notes:   Definitions only.
`ifndef RXCD_REGS_SVH
`define RXCD_REGS_SVH
`define RXCD_CTRL_BLK_ADR 7'h20
`define RXCD_CTRL_BLK     9:3
`define RXCD_CTRL_IDX     2:0
`define RXCD_A_LOSS       10'h108
`define RXCD_A_CELL_TH    10'h109
`define RXCD_A_FRM_TH     10'h10a
`define RXCD_A_LABEL      10'h10b
`define RXCD_A_FLAGS      10'h115
`define RXCD_A_CNT_CLR    10'h116
`define RXCD_A_SEL        10'h117
`define RXCD_A_CAP_ID     10'h118
`define RXCD_A_CAP_OFS    10'h119
`define RXCD_A_CAP_FSEQ   10'h11a
`define RXCD_A_CAP_STATUS_CHANGE_SEQUENCE   10'h11b
`define RXCD_A_CAP_CNT    10'h11c
`define RXCD_A_CAP_LID    10'h11d
`define RXCD_A_CAP_ST     10'h11e
`define RXCD_RST_CTRL     8'h0c
`define RXCD_RST_LOSS     8'h0c
`define RXCD_RST_CELL_TH  8'h67
`define RXCD_RST_FRM_TH   8'h91
`define RXCD_RST_LABEL    8'h00
`define RXCD_RST_FSEQ     8'h01
`define RXCD_RST_LID      8'h20
`define RXCD_RST_TMR      9'h018
`define RXCD_LC_IMA       6
`define RXCD_LC_DESCR     5
`define RXCD_LC_UNASG     4
`define RXCD_LC_IDLE      3
`define RXCD_LC_HECDIS    2
`define RXCD_LC_COSET     1
`define RXCD_LC_CORR      0
`define RXCD_CT_DELTA     7:4
`define RXCD_CT_SYNC_EXIT_COUNT     3:0
`define RXCD_FT_SYNC_EXIT_COUNT     7:6
`define RXCD_FT_ERRORED_CONTROL_CELL_COUNT      5:3
`define RXCD_FT_VALID_CONTROL_CELL_COUNT     2:0
`define RXCD_SEL_F        2:0
`define RXCD_CELL_LAST    9'h1a7
`define RXCD_PAY_LAST     9'h180
`define RXCD_HEC_POLY     8'h07
`define RXCD_COSET        8'h55
`define RXCD_IDLE_HDR     32'h0000_0001
`define RXCD_UNASG_MASK   32'hffff_fff1
`define RXCD_CD_HUNT      2'h0
`define RXCD_CD_PRE       2'h1
`define RXCD_CD_SYNC      2'h2
`define RXCD_IMA_STUFF    2'h3
`endif

// file: rtl/rxcd_pkg.sv
// Purpose: Types shared by the receive delineation block and its users.
// Assumes: Eight links.
// Notes:   Sync states are Gray coded; reported codes are mapped apart.
package rxcd_pkg;
  typedef enum logic [1:0] {
    RXCD_HUNT = 2'h0, RXCD_PRE = 2'h1, RXCD_SYNC = 2'h3
  } rxcd_sync_e;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rxcd_bus_s;
  typedef struct packed {
    logic       valid;
    logic       ok;
    logic       errored;
    logic       stuff;
    logic [7:0] ima_id;
    logic [7:0] fseq;
    logic [7:0] offset;
    logic [7:0] status_change_sequence;
    logic [4:0] lid;
    logic       ref_link;
    logic [1:0] m_code;
  } rxcd_icp_s;
  typedef struct packed {
    logic store;
    logic drop;
    logic pay_vld;
    logic pay_bit;
  } rxcd_cell_s;
  typedef struct packed {
    logic        b1, b2, s1, s2, s3;
    logic [39:0] sh;
    logic [8:0]  bc;
    rxcd_sync_e  cd;
    logic [3:0]  cnt;
    logic [8:0]  tmr;
    logic        cell_delineation_loss;
    logic [42:0] dsr;
    rxcd_sync_e  ist;
    logic [2:0]  icnt;
    logic [2:0]  ecnt;
  } rxcd_lnk_s;
  typedef logic [7:0] rxcd_byte_t;
endpackage

// file: rtl/rxcd_top.sv
// Purpose: Receive cell delineation, header check, cell filtering, frame
//          delineation and captured link values for eight links.
// Assumes: One bit per rising edge of each link strobe pin; strobe pins are
//          much slower than clk_sys. Link control cell decode is upstream.
// Notes:   Register reads answer one cycle after the read strobe.
// What this block does
// - Mode bit picks frame or plain processing
// - Descramble bit enables payload descrambling
// - Plain mode drops unassigned cells when enabled
// - Plain mode drops idle cells when enabled
// - Errored headers dropped only when discard set
// - Bypass bit removes coset from header check
// - Correction bit repairs single header bit errors in sync only
// - Enough good headers move presync to sync
// - Enough bad headers drop sync to hunt
// - Loss timer loads twice period, per cell
// - Invalid control cells drop frame sync
// - Errored control cells drop frame sync
// - Valid control cells raise frame presync
// - Sticky slip flag per link, write zero
// - Writing zero clears that link's slip counter
// - Select field chooses the captured link
// - Select write refreshes all captured values
// - Report group id, sequence, change sequence
// - Captured offset keeps only bits M needs
// - Report selected link slip counter
// - Report frame loss, delineation loss, reference, id
// - Report frame length and both sync states
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "rxcd_regs.svh"
module rxcd_top (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire rxcd_pkg::rxcd_bus_s    bus,
  output logic [7:0]                  rd_data,
  input  wire logic [7:0]             link_bit,
  input  wire logic [7:0]             link_strobe,
  input  wire rxcd_pkg::rxcd_icp_s [7:0] icp_in,
  output rxcd_pkg::rxcd_cell_s [7:0]  cell_out,
  output logic [7:0]                  lcd_out
);
  import rxcd_pkg::*;

  function automatic logic [7:0] rxcd_crc8(input logic [31:0] d);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int k = 31; k >= 0; k--) begin
      fb = c[7] ^ d[k];
      c  = {c[6:0], 1'b0} ^ (fb ? `RXCD_HEC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Syndrome of a single flipped bit matches: the header is repairable
  function automatic logic rxcd_fixable(input logic [7:0] syn);
    logic [39:0] e;
    logic        hit;
    hit = 1'b0;
    for (int k = 0; k < 40; k++) begin
      e = 40'h00_0000_0001 << k;
      if ((rxcd_crc8(e[39:8]) ^ e[7:0]) == syn) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic rxcd_reach(input logic [3:0] c,
                                      input logic [3:0] th);
    return ({1'b0, c} + 5'h01) >= {1'b0, th};
  endfunction

  function automatic logic [1:0] rxcd_code(input rxcd_sync_e s);
    case (s)
      RXCD_PRE:  return `RXCD_CD_PRE;
      RXCD_SYNC: return `RXCD_CD_SYNC;
      default:   return `RXCD_CD_HUNT;
    endcase
  endfunction

  function automatic logic [7:0] rxcd_ofs_mask(input logic [1:0] m);
    case (m)
      2'h0:    return 8'h1f;
      2'h1:    return 8'h3f;
      2'h2:    return 8'h7f;
      default: return 8'hff;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  rxcd_byte_t [7:0] ctrl_r, ctrl_nxt;
  rxcd_byte_t       loss_r, loss_nxt, cth_r, cth_nxt, fth_r, fth_nxt;
  rxcd_byte_t       label_r, label_nxt, flags_r, flags_nxt;
  rxcd_byte_t       clr_r, clr_nxt, rd_nxt;
  logic [2:0]       sel_r, sel_nxt;
  rxcd_byte_t [6:0] cap_r, cap_nxt;
  rxcd_byte_t [7:0] scnt_r, scnt_nxt;
  rxcd_lnk_s  [7:0] lk_r, lk_nxt;
  rxcd_icp_s  [7:0] icp_r, icp_nxt;
  rxcd_cell_s [7:0] cell_nxt;
  logic [7:0]       ev, bnd, good, bad, idle, unasg, slip_ev, lcd_nxt;
  logic [39:0]      win [8];
  logic [7:0]       syn [8];
  logic             pay;

  ////////////////////////////////////////////////////////////////////////
  // Link group
  always_comb begin
    lk_nxt   = lk_r;
    icp_nxt  = icp_r;
    cell_nxt = '0;
    for (int i = 0; i < 8; i++) begin
      lk_nxt[i].b1 = link_bit[i];
      lk_nxt[i].b2 = lk_r[i].b1;
      lk_nxt[i].s1 = link_strobe[i];
      lk_nxt[i].s2 = lk_r[i].s1;
      lk_nxt[i].s3 = lk_r[i].s2;
      ev[i]  = lk_r[i].s2 & ~lk_r[i].s3;
      win[i] = {lk_r[i].sh[38:0], lk_r[i].b2};
      syn[i] = rxcd_crc8(win[i][39:8]) ^ win[i][7:0] ^
               (ctrl_r[i][`RXCD_LC_COSET] ? 8'h00 : `RXCD_COSET);
      good[i] = (syn[i] == 8'h00);
      bad[i]  = ~good[i] & ~(ctrl_r[i][`RXCD_LC_CORR] &
                rxcd_fixable(syn[i]));
      bnd[i]  = ev[i] & (lk_r[i].bc == `RXCD_CELL_LAST);
      idle[i] = (win[i][39:8] == `RXCD_IDLE_HDR);
      unasg[i] = ((win[i][39:8] & `RXCD_UNASG_MASK) == 32'h0000_0000);
      pay = 1'b0;
      if (ev[i]) begin
        lk_nxt[i].sh = win[i];
        lk_nxt[i].bc = bnd[i] ? 9'h000 : 9'(lk_r[i].bc + 9'h001);
        pay = (lk_r[i].cd == RXCD_SYNC) && !bnd[i] &&
              (lk_r[i].bc < `RXCD_PAY_LAST);
      end
      case (lk_r[i].cd)
        RXCD_HUNT: begin
          if (ev[i] && good[i]) begin
            lk_nxt[i].cd  = RXCD_PRE;
            lk_nxt[i].cnt = 4'h0;
            lk_nxt[i].bc  = 9'h000;
          end
        end
        RXCD_PRE: begin
          if (bnd[i] && !good[i]) begin
            lk_nxt[i].cd = RXCD_HUNT;
          end else if (bnd[i] &&
                       rxcd_reach(lk_r[i].cnt, cth_r[`RXCD_CT_DELTA])) begin
            lk_nxt[i].cd  = RXCD_SYNC;
            lk_nxt[i].cnt = 4'h0;
          end else if (bnd[i]) begin
            lk_nxt[i].cnt = 4'(lk_r[i].cnt + 4'h1);
          end
        end
        RXCD_SYNC: begin
          if (bnd[i] && !bad[i]) begin
            lk_nxt[i].cnt = 4'h0;
          end else if (bnd[i] &&
                       rxcd_reach(lk_r[i].cnt, cth_r[`RXCD_CT_SYNC_EXIT_COUNT])) begin
            lk_nxt[i].cd  = RXCD_HUNT;
            lk_nxt[i].cnt = 4'h0;
          end else if (bnd[i]) begin
            lk_nxt[i].cnt = 4'(lk_r[i].cnt + 4'h1);
          end
        end
        default: lk_nxt[i].cd = RXCD_HUNT;
      endcase
      // Timer counts cell periods; a zero period trips at once
      if (lk_r[i].cd == RXCD_SYNC) begin
        lk_nxt[i].tmr = {loss_r, 1'b0};
        lk_nxt[i].cell_delineation_loss = 1'b0;
      end else if (lk_r[i].tmr == 9'h000) begin
        lk_nxt[i].cell_delineation_loss = 1'b1;
      end else if (bnd[i]) begin
        lk_nxt[i].tmr = 9'(lk_r[i].tmr - 9'h001);
        lk_nxt[i].cell_delineation_loss = (lk_r[i].tmr == 9'h001);
      end
      if (pay) begin
        lk_nxt[i].dsr = {lk_r[i].dsr[41:0], lk_r[i].b2};
        cell_nxt[i].pay_vld = 1'b1;
        cell_nxt[i].pay_bit = lk_r[i].b2 ^
          (ctrl_r[i][`RXCD_LC_DESCR] & lk_r[i].dsr[42]);
      end
      if (bnd[i] && lk_r[i].cd == RXCD_SYNC) begin
        cell_nxt[i].drop =
          (ctrl_r[i][`RXCD_LC_HECDIS] & bad[i]) |
          (~ctrl_r[i][`RXCD_LC_IMA] & ctrl_r[i][`RXCD_LC_IDLE] &
           idle[i]) |
          (~ctrl_r[i][`RXCD_LC_IMA] & ctrl_r[i][`RXCD_LC_UNASG] &
           unasg[i]);
        cell_nxt[i].store = ~cell_nxt[i].drop;
      end
      lcd_nxt[i] = lk_nxt[i].cell_delineation_loss;
      // Values keep updating in plain mode so software can still read them
      if (icp_in[i].valid && icp_in[i].ok) begin
        icp_nxt[i] = icp_in[i];
      end
      slip_ev[i] = 1'b0;
      if (!ctrl_r[i][`RXCD_LC_IMA]) begin
        lk_nxt[i].ist  = RXCD_HUNT;
        lk_nxt[i].icnt = 3'h0;
        lk_nxt[i].ecnt = 3'h0;
      end else if (icp_in[i].valid) begin
        case (lk_r[i].ist)
          RXCD_HUNT: begin
            if (icp_in[i].ok) begin
              lk_nxt[i].ist  = RXCD_PRE;
              lk_nxt[i].icnt = 3'h0;
            end
          end
          RXCD_PRE: begin
            if (!icp_in[i].ok) begin
              lk_nxt[i].ist = RXCD_HUNT;
            end else if (rxcd_reach({1'b0, lk_r[i].icnt},
                                    {1'b0, fth_r[`RXCD_FT_VALID_CONTROL_CELL_COUNT]})) begin
              lk_nxt[i].ist  = RXCD_SYNC;
              lk_nxt[i].icnt = 3'h0;
              lk_nxt[i].ecnt = 3'h0;
            end else begin
              lk_nxt[i].icnt = 3'(lk_r[i].icnt + 3'h1);
            end
          end
          RXCD_SYNC: begin
            if (icp_in[i].ok) begin
              lk_nxt[i].icnt = 3'h0;
              lk_nxt[i].ecnt = 3'h0;
            end else if (icp_in[i].errored) begin
              lk_nxt[i].icnt = 3'h0;
              lk_nxt[i].ecnt = 3'(lk_r[i].ecnt + 3'h1);
              if (rxcd_reach({1'b0, lk_r[i].ecnt},
                             {1'b0, fth_r[`RXCD_FT_ERRORED_CONTROL_CELL_COUNT]})) begin
                lk_nxt[i].ist = RXCD_HUNT;
                slip_ev[i]    = 1'b1;
              end
            end else begin
              lk_nxt[i].ecnt = 3'h0;
              lk_nxt[i].icnt = 3'(lk_r[i].icnt + 3'h1);
              if (rxcd_reach({1'b0, lk_r[i].icnt},
                             {2'h0, fth_r[`RXCD_FT_SYNC_EXIT_COUNT]})) begin
                lk_nxt[i].ist = RXCD_HUNT;
                slip_ev[i]    = 1'b1;
              end
            end
          end
          default: lk_nxt[i].ist = RXCD_HUNT;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lk_r     <= '0;
      icp_r    <= '0;
      cell_out <= '0;
      lcd_out  <= '0;
      for (int i = 0; i < 8; i++) begin
        lk_r[i].tmr <= `RXCD_RST_TMR;
      end
    end else begin
      lk_r     <= lk_nxt;
      icp_r    <= icp_nxt;
      cell_out <= cell_nxt;
      lcd_out  <= lcd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register group
  always_comb begin
    logic [2:0] s;
    logic       lfl;
    s          = bus.wdata[`RXCD_SEL_F];
    lfl        = 1'b0;
    ctrl_nxt   = ctrl_r;
    loss_nxt   = loss_r;
    cth_nxt    = cth_r;
    fth_nxt    = fth_r;
    label_nxt  = label_r;
    clr_nxt    = clr_r;
    sel_nxt    = sel_r;
    cap_nxt    = cap_r;
    flags_nxt  = flags_r;
    scnt_nxt   = scnt_r;
    rd_nxt     = 8'h00;
    if (bus.wr) begin
      if (bus.addr[`RXCD_CTRL_BLK] == `RXCD_CTRL_BLK_ADR) begin
        ctrl_nxt[bus.addr[`RXCD_CTRL_IDX]] = bus.wdata;
      end
      case (bus.addr)
        `RXCD_A_LOSS:    loss_nxt  = bus.wdata;
        `RXCD_A_CELL_TH: cth_nxt   = bus.wdata;
        `RXCD_A_FRM_TH:  fth_nxt   = bus.wdata;
        `RXCD_A_LABEL:   label_nxt = bus.wdata;
        `RXCD_A_FLAGS:   flags_nxt = flags_r & bus.wdata;
        `RXCD_A_CNT_CLR: clr_nxt   = bus.wdata;
        `RXCD_A_SEL: begin
          sel_nxt = s;
          lfl = ctrl_r[s][`RXCD_LC_IMA] && lk_r[s].ist != RXCD_SYNC;
          // Snapshot of the newly chosen link
          cap_nxt[0] = icp_r[s].ima_id;
          cap_nxt[1] = icp_r[s].offset &
                       rxcd_ofs_mask(icp_r[s].m_code);
          cap_nxt[2] = icp_r[s].fseq;
          cap_nxt[3] = icp_r[s].status_change_sequence;
          cap_nxt[4] = scnt_r[s];
          cap_nxt[5] = {lfl, lk_r[s].cell_delineation_loss, icp_r[s].ref_link,
                        icp_r[s].lid};
          cap_nxt[6] = {2'h0, icp_r[s].m_code,
                        (icp_r[s].stuff && lk_r[s].ist == RXCD_SYNC) ?
                        `RXCD_IMA_STUFF : rxcd_code(lk_r[s].ist),
                        rxcd_code(lk_r[s].cd)};
        end
        default: ;
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      if (bus.wr && bus.addr == `RXCD_A_CNT_CLR && !bus.wdata[i]) begin
        scnt_nxt[i] = 8'h00;
      end
      // A slip in the clearing cycle still counts and still flags
      if (slip_ev[i]) begin
        flags_nxt[i] = 1'b1;
        if (scnt_nxt[i] != 8'hff) begin
          scnt_nxt[i] = 8'(scnt_nxt[i] + 8'h01);
        end
      end
    end
    if (bus.rd) begin
      if (bus.addr[`RXCD_CTRL_BLK] == `RXCD_CTRL_BLK_ADR) begin
        rd_nxt = ctrl_r[bus.addr[`RXCD_CTRL_IDX]];
      end
      case (bus.addr)
        `RXCD_A_LOSS:     rd_nxt = loss_r;
        `RXCD_A_CELL_TH:  rd_nxt = cth_r;
        `RXCD_A_FRM_TH:   rd_nxt = fth_r;
        `RXCD_A_LABEL:    rd_nxt = label_r;
        `RXCD_A_FLAGS:    rd_nxt = flags_r;
        `RXCD_A_CNT_CLR:  rd_nxt = clr_r;
        `RXCD_A_SEL:      rd_nxt = {5'h00, sel_r};
        `RXCD_A_CAP_ID:   rd_nxt = cap_r[0];
        `RXCD_A_CAP_OFS:  rd_nxt = cap_r[1];
        `RXCD_A_CAP_FSEQ: rd_nxt = cap_r[2];
        `RXCD_A_CAP_STATUS_CHANGE_SEQUENCE: rd_nxt = cap_r[3];
        `RXCD_A_CAP_CNT:  rd_nxt = cap_r[4];
        `RXCD_A_CAP_LID:  rd_nxt = cap_r[5];
        `RXCD_A_CAP_ST:   rd_nxt = cap_r[6];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r  <= {8{`RXCD_RST_CTRL}};
      loss_r  <= `RXCD_RST_LOSS;
      cth_r   <= `RXCD_RST_CELL_TH;
      fth_r   <= `RXCD_RST_FRM_TH;
      label_r <= `RXCD_RST_LABEL;
      flags_r <= 8'h00;
      clr_r   <= 8'h00;
      sel_r   <= 3'h0;
      cap_r   <= '0;
      cap_r[2] <= `RXCD_RST_FSEQ;
      cap_r[5] <= `RXCD_RST_LID;
      scnt_r  <= '0;
      rd_data <= 8'h00;
    end else begin
      ctrl_r  <= ctrl_nxt;
      loss_r  <= loss_nxt;
      cth_r   <= cth_nxt;
      fth_r   <= fth_nxt;
      label_r <= label_nxt;
      flags_r <= flags_nxt;
      clr_r   <= clr_nxt;
      sel_r   <= sel_nxt;
      cap_r   <= cap_nxt;
      scnt_r  <= scnt_nxt;
      rd_data <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on link 0 and the register side
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_hunt_to_presync: assert property (
    lk_r[0].cd == RXCD_HUNT && ev[0] && good[0] |=> lk_r[0].cd == RXCD_PRE)
    else $error("hunt did not enter presync on a good header");
  a_presync_err_hunt: assert property (
    lk_r[0].cd == RXCD_PRE && bnd[0] && !good[0] |=> lk_r[0].cd == RXCD_HUNT)
    else $error("presync kept after a bad header");
  a_presync_to_sync: assert property (
    lk_r[0].cd == RXCD_PRE && bnd[0] && good[0] &&
    ({1'b0, lk_r[0].cnt} + 5'h01 >= {1'b0, cth_r[`RXCD_CT_DELTA]})
    |=> lk_r[0].cd == RXCD_SYNC)
    else $error("presync did not reach sync at the count");
  a_sync_to_hunt: assert property (
    lk_r[0].cd == RXCD_SYNC && bnd[0] && bad[0] &&
    ({1'b0, lk_r[0].cnt} + 5'h01 >= {1'b0, cth_r[`RXCD_CT_SYNC_EXIT_COUNT]})
    |=> lk_r[0].cd == RXCD_HUNT)
    else $error("sync not lost at the bad header count");
  a_timer_load: assert property (
    lk_r[0].cd == RXCD_SYNC |=> lk_r[0].tmr == {$past(loss_r), 1'b0}
    && !lk_r[0].cell_delineation_loss)
    else $error("loss timer not loaded with twice the period");
  a_frame_off: assert property (
    !ctrl_r[0][`RXCD_LC_IMA] |=> lk_r[0].ist == RXCD_HUNT)
    else $error("frame machine runs in plain mode");
  a_idle_drop: assert property (
    bnd[0] && lk_r[0].cd == RXCD_SYNC && ctrl_r[0][`RXCD_LC_IDLE] &&
    !ctrl_r[0][`RXCD_LC_IMA] && idle[0]
    |=> cell_out[0].drop && !cell_out[0].store)
    else $error("idle cell stored while discard set");
  a_flag_sticky: assert property (
    slip_ev[0] |=> flags_r[0] ##1 (flags_r[0] || $past(bus.wr)))
    else $error("slip flag not set or not sticky");
  a_count_clear: assert property (
    bus.wr && bus.addr == `RXCD_A_CNT_CLR && !bus.wdata[0] && !slip_ev[0]
    |=> scnt_r[0] == 8'h00)
    else $error("slip counter not cleared by a zero write");
  a_capture_sel: assert property (
    bus.wr && bus.addr == `RXCD_A_SEL
    |=> sel_r == $past(bus.wdata[`RXCD_SEL_F]) &&
    cap_r[4] == $past(scnt_r[bus.wdata[`RXCD_SEL_F]]))
    else $error("captured values not refreshed on select write");
  a_read_once: assert property (
    !bus.rd |=> rd_data == 8'h00)
    else $error("read data outside its cycle");

  c_reach_sync: cover property (lk_r[0].cd == RXCD_PRE ##1
                                lk_r[0].cd == RXCD_SYNC);
  c_frame_slip: cover property (slip_ev[0]);
  c_cell_drop:  cover property (cell_out[0].drop);
  c_capture:    cover property (bus.wr && bus.addr == `RXCD_A_SEL);
endmodule

// file: dv/rxcd_framer.sv
// Purpose: Far-side framer model feeding one cell stream to all links.
// Assumes: Six clk_sys cycles per bit, strobe high for three of them.
// Notes:   After its hold the data line shows the inverse of the last bit.
`timescale 1ns/1ps
module rxcd_framer (
  input  wire logic       clk_sys,
  output logic      [7:0] link_bit,
  output logic      [7:0] link_strobe
);
  initial begin
    link_bit    = 8'h00;
    link_strobe = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////
  // Header check with the coset added, MSB of the header first
  function automatic logic [7:0] hec(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    end
    return c ^ 8'h55;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // Strobe stands still low between bits; no free-running clock
  task automatic send_bit(input logic b);
    @(posedge clk_sys);
    link_bit    <= {8{b}};
    link_strobe <= 8'hff;
    repeat (3) @(posedge clk_sys);
    link_strobe <= 8'h00;
    repeat (2) @(posedge clk_sys);
    link_bit    <= {8{~b}};
  endtask
  // Bad flips the last check bit, a single correctable error
  task automatic send_cell(input logic [31:0] hdr, input logic bad);
    logic [39:0] w;
    w = {hdr, hec(hdr) ^ {7'h00, bad}};
    for (int i = 39; i >= 0; i--) begin
      send_bit(w[i]);
    end
    for (int i = 0; i < 384; i++) begin
      send_bit(hdr[i % 32] ^ i[0]);
    end
  endtask
endmodule

// file: dv/rxcd_top_tb_top.sv
// Purpose: Self-checking bench for the receive delineation block.
// Assumes: Only link 0 results are checked; all links see one stream.
// Notes:   Cell decisions are checked against a queue of expectations.
`timescale 1ns/1ps
module rxcd_top_tb_top;
  import rxcd_pkg::*;
  logic                  clk_sys = 1'b0;
  logic                  rst     = 1'b1;
  rxcd_bus_s             bus     = '0;
  rxcd_icp_s [7:0]       icp_in  = '0;
  logic      [7:0]       rd_data;
  logic      [7:0]       link_bit;
  logic      [7:0]       link_strobe;
  rxcd_cell_s [7:0]      cell_out;
  logic      [7:0]       lcd_out;
  logic      [31:0]      seed    = 32'h663e10f2;
  int                    failures   = 0;
  int                    num_checks = 0;
  logic                  armed   = 1'b0;
  logic                  exp_q [$];
  logic                  pay_q [$];
  logic      [9:0]       ra [14] = '{10'h100, 10'h108, 10'h109, 10'h10a,
    10'h116, 10'h117, 10'h118, 10'h119, 10'h11a, 10'h11b, 10'h11c,
    10'h11d, 10'h11e, 10'h3ff};
  logic      [7:0]       rv [14] = '{8'h0c, 8'h0c, 8'h67, 8'h91, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
  logic      [31:0]      ch [8]  = '{32'h00a5_3c20, 32'h1, 32'h00a5_3c20,
    32'h0, 32'h0, 32'h1, 32'h00a5_3c20, 32'h00a5_3c20};
  logic                  cb [8]  = '{0, 0, 1, 0, 0, 0, 1, 0};
  logic                  ce [8]  = '{1, 0, 0, 1, 0, 1, 1, 0};
  always #25 clk_sys = ~clk_sys;
  rxcd_top u_dut (.clk_sys(clk_sys), .rst(rst), .bus(bus),
    .rd_data(rd_data), .link_bit(link_bit), .link_strobe(link_strobe),
    .icp_in(icp_in), .cell_out(cell_out), .lcd_out(lcd_out));
  rxcd_framer u_fr (.clk_sys(clk_sys), .link_bit(link_bit),
    .link_strobe(link_strobe));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [7:0] exp, seen);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus <= {a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 d = rd_data;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Registered pulses are looked at mid-cycle, where they have settled
  always @(negedge clk_sys) begin
    if (armed && (cell_out[0].store === 1'b1 || cell_out[0].drop === 1'b1))
    begin
      if (exp_q.size() == 0) begin
        chk("cell_extra", 8'h00, 8'h01);
      end else begin
        chk("cell_store", {7'h00, exp_q.pop_front()},
            {7'h00, cell_out[0].store});
      end
    end
    if (armed && cell_out[0].pay_vld === 1'b1) begin
      chk("pay_bit", {7'h00, pay_q.pop_front()},
          {7'h00, cell_out[0].pay_bit});
    end
  end
  // Whole run is about 46k cycles; this bound only cuts a hang
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
  end
  initial begin
    logic [7:0]  d;
    logic [31:0] r;
    rxcd_icp_s   ic;
    wait (rst === 1'b0);
    for (int i = 0; i < 14; i++) begin
      rd(ra[i], d);
      chk("reset_value", rv[i], d);
    end
    r = xs();
    wr(10'h10b, r[7:0]);
    rd(10'h10b, d);
    chk("label", r[7:0], d);
    // Loss period is never written as zero
    wr(10'h108, 8'h40);
    rd(10'h108, d);
    chk("loss_period", 8'h40, d);
    wr(10'h118, r[15:8]);
    rd(10'h118, d);
    chk("ro_id", 8'h00, d);
    wr(10'h116, 8'h5a);
    rd(10'h116, d);
    chk("cnt_clr", 8'h5a, d);
    wr(10'h115, 8'h00);
    rd(10'h115, d);
    chk("slip_flags", 8'h00, d);
    // Margin of cells covers a false lock inside the first window
    repeat (10) u_fr.send_cell(xs() | 32'h0010_0000, 1'b0);
    ic = '0;
    ic.valid = 1'b1;
    ic.ok = 1'b1;
    {ic.ima_id, ic.fseq, ic.status_change_sequence, ic.offset} = r;
    ic.lid = r[12:8];
    ic.ref_link = 1'b1;
    @(posedge clk_sys);
    icp_in[0] <= ic;
    @(posedge clk_sys);
    icp_in[0] <= '0;
    wr(10'h117, 8'h00);
    rd(10'h11e, d);
    chk("states", 8'h02, d & 8'h33);
    chk("lcd", 8'h00, {7'h00, lcd_out[0]});
    rd(10'h118, d);
    chk("cap_id", r[31:24], d);
    rd(10'h119, d);
    chk("cap_ofs", r[7:0] & 8'h1f, d);
    rd(10'h11a, d);
    chk("cap_fseq", r[23:16], d);
    rd(10'h11b, d);
    chk("cap_status_change_sequence", r[15:8], d);
    rd(10'h11c, d);
    chk("cap_cnt", 8'h00, d);
    rd(10'h11d, d);
    chk("cap_lid", {3'b001, r[12:8]}, d);
    armed = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        wr(10'h100, 8'h15);
      end
      if (i == 7) begin
        wr(10'h100, 8'h06);
      end
      exp_q.push_back(ce[i]);
      for (int k = 0; k < 384; k++) begin
        pay_q.push_back(ch[i][k % 32] ^ k[0]);
      end
      u_fr.send_cell(ch[i], cb[i]);
    end
    repeat (20) @(posedge clk_sys);
    chk("cells_left", 8'h00, {7'h00, exp_q.size() != 0});
    chk("pay_left", 8'h00, {7'h00, pay_q.size() != 0});
    wr(10'h100, 8'h40);
    wr(10'h117, 8'h00);
    rd(10'h11d, d);
    chk("frame_loss", 8'h01, {7'h00, d[7]});
    // Two frame sync losses: errored control cells, then invalid ones
    ic.m_code = 2'h2;
    for (int i = 0; i < 8; i++) begin
      ic.ok      = (i[1] == 1'b0);
      ic.errored = (i < 4) && !ic.ok;
      @(posedge clk_sys);
      icp_in[0] <= ic;
      @(posedge clk_sys);
      icp_in[0] <= '0;
    end
    rd(10'h115, d);
    chk("slip_set", 8'h01, d);
    wr(10'h117, 8'h00);
    rd(10'h11c, d);
    chk("slip_count", 8'h02, d);
    rd(10'h119, d);
    chk("cap_ofs_128", r[7:0] & 8'h7f, d);
    rd(10'h11e, d);
    chk("states_hunt", 8'h22, d);
    wr(10'h115, 8'h00);
    wr(10'h116, 8'hfe);
    wr(10'h117, 8'h00);
    rd(10'h115, d);
    chk("slip_clear", 8'h00, d);
    rd(10'h11c, d);
    chk("count_clear", 8'h00, d);
    tally_and_finish();
  end
endmodule
